// file: logic/lps_pkg.sv
// Package of commands, states and timing counts shared by both ends of the link.
package lps_pkg;
   // ==========================================================================
   // Geometry and command/address layout
   // ==========================================================================
   localparam int unsigned LPS_NUM_BANKS = 8;
   localparam int unsigned LPS_BA_W = 3;
   localparam int unsigned LPS_CA_W = 10;
   localparam int unsigned LPS_BA_LSB = 7;
   localparam int unsigned LPS_AP_BIT = 0;
   localparam int unsigned LPS_AB_BIT = 4;

   // ==========================================================================
   // Timing, in nanoseconds, and the derived cycle counts at 50 MHz
   // ==========================================================================
   localparam int unsigned LPS_CLK_PERIOD_NS = 20;
   localparam int unsigned LPS_T_RP_NS = 18;
   localparam int unsigned LPS_T_RCD_NS = 18;
   localparam int unsigned LPS_T_RFCPB_NS = 90;
   localparam int unsigned LPS_T_RFCAB_NS = 130;
   localparam int unsigned LPS_T_MRR_NS = 40;
   localparam int unsigned LPS_T_MRW_NS = 100;
   localparam int unsigned LPS_T_XP_NS = 8;
   localparam int unsigned LPS_T_XSR_NS = 140;
   localparam int unsigned LPS_T_INIT_NS = 10000;
   localparam int unsigned LPS_T_BURST_NS = 80;

   // Least times round up, never below one cycle.
   function automatic int unsigned lps_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + LPS_CLK_PERIOD_NS - 1) / LPS_CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned LPS_RP_CYC = lps_cyc(LPS_T_RP_NS);
   localparam int unsigned LPS_RCD_CYC = lps_cyc(LPS_T_RCD_NS);
   localparam int unsigned LPS_RFCPB_CYC = lps_cyc(LPS_T_RFCPB_NS);
   localparam int unsigned LPS_RFCAB_CYC = lps_cyc(LPS_T_RFCAB_NS);
   localparam int unsigned LPS_MRR_CYC = lps_cyc(LPS_T_MRR_NS);
   localparam int unsigned LPS_MRW_CYC = lps_cyc(LPS_T_MRW_NS);
   localparam int unsigned LPS_XP_CYC = lps_cyc(LPS_T_XP_NS);
   localparam int unsigned LPS_XSR_CYC = lps_cyc(LPS_T_XSR_NS);
   localparam int unsigned LPS_INIT_CYC = lps_cyc(LPS_T_INIT_NS);
   localparam int unsigned LPS_BURST_CYC = lps_cyc(LPS_T_BURST_NS);
   localparam int unsigned LPS_CNT_W = 16;

   // ==========================================================================
   // Decoded commands
   // ==========================================================================
   typedef enum logic [3:0] {
      LPS_CMD_NOP, LPS_CMD_ACT, LPS_CMD_RD, LPS_CMD_WR, LPS_CMD_PRE, LPS_CMD_BST,
      LPS_CMD_REFPB, LPS_CMD_REFAB, LPS_CMD_MRR, LPS_CMD_MRW, LPS_CMD_RESET,
      LPS_CMD_SREF, LPS_CMD_DSLEEP, LPS_CMD_PDN
   } lps_cmd_e;

   // Device power state.
   typedef enum logic [3:0] {
      LPS_PWR_ON, LPS_RESETTING, LPS_RUN, LPS_APD, LPS_IPD, LPS_RPD,
      LPS_SREF, LPS_DEEP, LPS_MRW_ST, LPS_MRR_ST, LPS_REFAB_ST
   } lps_dev_e;

   // Per-bank state.
   typedef enum logic [2:0] {
      LPS_B_IDLE, LPS_B_ACTIVATING, LPS_B_ACTIVE, LPS_B_READING, LPS_B_WRITING,
      LPS_B_PRECHARGING, LPS_B_REFRESHING, LPS_B_MRREADING
   } lps_bank_e;
endpackage

// file: logic/lps_if.sv
// Interface carrying clock enable, chip select and command/address between the ends.
interface lps_if;
   import lps_pkg::*;
   logic cke;
   logic cs_b;
   logic [LPS_CA_W-1:0] ca;
   modport ctrl (output cke, output cs_b, output ca);
   modport mem (input cke, input cs_b, input ca);
endinterface

// file: logic/lps_bank.sv
// One bank's command state machine with its own timer.
module lps_bank
   import lps_pkg::*;
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Command directed at this bank, already accepted by the device.
   input wire logic i_go,
   input wire lps_cmd_e i_cmd,
   input wire logic i_ap,
   input wire logic i_bst,
   input wire logic i_all_idle,
   // State view.
   output lps_bank_e o_state,
   output logic o_illegal
);
   typedef struct packed {
      lps_bank_e st;
      logic ap;
      logic [LPS_CNT_W-1:0] cnt;
   } lps_bank_s;

   lps_bank_s bank_reg;
   lps_bank_s bank_next;

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   always_comb begin
      bank_next = bank_reg;
      o_illegal = 1'b0;
      if (bank_reg.cnt != '0) begin
         bank_next.cnt = bank_reg.cnt - 1'b1;
      end
      // Timer expiry ends timed states.
      if (bank_reg.cnt == LPS_CNT_W'(1)) begin
         unique case (bank_reg.st)
            LPS_B_ACTIVATING: bank_next.st = LPS_B_ACTIVE;
            LPS_B_MRREADING: bank_next.st = LPS_B_ACTIVE;
            LPS_B_READING, LPS_B_WRITING: begin
               if (bank_reg.ap) begin
                  bank_next.st = LPS_B_PRECHARGING;
                  bank_next.ap = 1'b0;
                  bank_next.cnt = LPS_CNT_W'(LPS_RP_CYC);
               end else begin
                  bank_next.st = LPS_B_ACTIVE;
               end
            end
            default: bank_next.st = LPS_B_IDLE;
         endcase
      end
      if (i_bst) begin
         bank_next.st = LPS_B_ACTIVE;
         bank_next.ap = 1'b0;
         bank_next.cnt = '0;
      end
      if (i_go) begin
         unique case (bank_reg.st)
            LPS_B_IDLE: begin
               if (i_cmd == LPS_CMD_ACT) begin
                  bank_next.st = LPS_B_ACTIVATING;
                  bank_next.cnt = LPS_CNT_W'(LPS_RCD_CYC);
               end else if (i_cmd == LPS_CMD_REFPB && i_all_idle) begin
                  bank_next.st = LPS_B_REFRESHING;
                  bank_next.cnt = LPS_CNT_W'(LPS_RFCPB_CYC);
               end else if (i_cmd == LPS_CMD_PRE) begin
                  bank_next.st = LPS_B_PRECHARGING;
                  bank_next.cnt = LPS_CNT_W'(LPS_RP_CYC);
               end else begin
                  o_illegal = 1'b1;
               end
            end
            LPS_B_ACTIVE, LPS_B_READING, LPS_B_WRITING: begin
               if (bank_reg.ap) begin
                  o_illegal = 1'b1;
               end else if (i_cmd == LPS_CMD_RD || i_cmd == LPS_CMD_WR) begin
                  bank_next.st = (i_cmd == LPS_CMD_RD) ? LPS_B_READING : LPS_B_WRITING;
                  bank_next.ap = i_ap;
                  bank_next.cnt = LPS_CNT_W'(LPS_BURST_CYC);
               end else if (i_cmd == LPS_CMD_PRE) begin
                  bank_next.st = LPS_B_PRECHARGING;
                  bank_next.cnt = LPS_CNT_W'(LPS_RP_CYC);
               end else if (i_cmd == LPS_CMD_MRR && bank_reg.st == LPS_B_ACTIVE) begin
                  bank_next.st = LPS_B_MRREADING;
                  bank_next.cnt = LPS_CNT_W'(LPS_MRR_CYC);
               end else begin
                  o_illegal = 1'b1;
               end
            end
            default: o_illegal = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bank_reg <= '{st: LPS_B_IDLE, ap: 1'b0, cnt: '0};
      end else begin
         bank_reg <= bank_next;
      end
   end

   assign o_state = bank_reg.st;
endmodule // lps_bank

// file: logic/lps_mem.sv
// Device end: power state tracking over eight bank state machines.
module lps_mem
   import lps_pkg::*;
#(
   parameter int unsigned INIT_CYC = LPS_INIT_CYC
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Link from the controller.
   lps_if.mem link,
   // Status toward the user side.
   output lps_dev_e o_dev_state,
   output logic [LPS_NUM_BANKS*3-1:0] o_bank_states,
   output logic o_illegal
);
   typedef struct packed {
      logic [1:0] cke_s;
      logic [1:0] cs_s;
      logic [LPS_CA_W-1:0] ca_s1;
      logic [LPS_CA_W-1:0] ca_s2;
      logic cke_prev;
      lps_dev_e dev;
      logic [LPS_CNT_W-1:0] cnt;
      logic [LPS_CNT_W-1:0] init_cnt;
      logic [LPS_BA_W-1:0] last_bank;
      logic illegal;
      logic [LPS_NUM_BANKS*3-1:0] bstate;
   } lps_mem_s;

   lps_mem_s mem_reg;
   lps_mem_s mem_next;
   lps_cmd_e cmd;
   logic cke;
   logic cs_b;
   logic [LPS_CA_W-1:0] ca;
   logic [LPS_BA_W-1:0] ba;
   logic all_idle;
   logic any_active;
   logic bank_cmd;
   logic [LPS_NUM_BANKS-1:0] go;
   logic [LPS_NUM_BANKS-1:0] burst_terminate_cmd;
   logic [LPS_NUM_BANKS-1:0] bill;
   logic [LPS_NUM_BANKS-1:0] bidle;
   lps_bank_e bst_st [LPS_NUM_BANKS];

   // ==========================================================================
   // Pin sampling and command decode
   // ==========================================================================
   // Edge-sampled select and enable.
   assign cke = mem_reg.cke_s[1];
   assign cs_b = mem_reg.cs_s[1];
   assign ca = mem_reg.ca_s2;
   assign ba = ca[LPS_BA_LSB +: LPS_BA_W];

   always_comb begin
      cmd = LPS_CMD_NOP;
      if (!cs_b) begin
         unique casez (ca[3:0])
            4'b0000: cmd = LPS_CMD_MRW;
            4'b1000: cmd = LPS_CMD_MRR;
            4'b0100: cmd = LPS_CMD_REFPB;
            4'b1100: cmd = LPS_CMD_REFAB;
            4'b??10: cmd = LPS_CMD_ACT;
            4'b0001: cmd = LPS_CMD_WR;
            4'b0101: cmd = LPS_CMD_RD;
            4'b1011: cmd = LPS_CMD_PRE;
            4'b0011: cmd = LPS_CMD_BST;
            default: cmd = LPS_CMD_NOP;
         endcase
         if (!cke && mem_reg.cke_prev) begin
            cmd = (ca[2:0] == 3'b100) ? LPS_CMD_SREF :
                  (ca[2:0] == 3'b011) ? LPS_CMD_DSLEEP : LPS_CMD_NOP;
         end
      end
   end

   // ==========================================================================
   // Bank array
   // ==========================================================================
   always_comb begin
      all_idle = &bidle;
      any_active = ~all_idle;
   end

   assign bank_cmd = mem_reg.dev == LPS_RUN && cke && mem_reg.cke_prev;

   for (genvar b = 0; b < LPS_NUM_BANKS; b++) begin : g_bank
      logic hit;
      assign bidle[b] = bst_st[b] == LPS_B_IDLE;
      assign hit = LPS_BA_W'(b) == ba;
      // Precharge-all reaches every bank; one still activating or mode reading flags it illegal and keeps its row open.
      assign go[b] = bank_cmd && ((hit && (cmd == LPS_CMD_ACT || cmd == LPS_CMD_RD ||
         cmd == LPS_CMD_WR || cmd == LPS_CMD_REFPB || (cmd == LPS_CMD_MRR && !all_idle) ||
         (cmd == LPS_CMD_PRE && !ca[LPS_AB_BIT]))) ||
         (cmd == LPS_CMD_PRE && ca[LPS_AB_BIT]));
      assign burst_terminate_cmd[b] = bank_cmd && cmd == LPS_CMD_BST && mem_reg.last_bank == LPS_BA_W'(b);
      assign o_bank_states[b*3 +: 3] = mem_reg.bstate[b*3 +: 3];
      lps_bank u_bank (
         .i_core_clk(i_core_clk),
         .i_rst_b(i_rst_b),
         .i_go(go[b]),
         .i_cmd(cmd),
         .i_ap(mem_reg.ca_s1[LPS_AP_BIT]),
         .i_bst(burst_terminate_cmd[b] && (bst_st[b] == LPS_B_READING || bst_st[b] == LPS_B_WRITING)),
         .i_all_idle(bidle[b]),
         .o_state(bst_st[b]),
         .o_illegal(bill[b])
      );
   end

   // ==========================================================================
   // Device power state machine
   // ==========================================================================
   always_comb begin
      mem_next = mem_reg;
      mem_next.cke_s = {mem_reg.cke_s[0], link.cke};
      mem_next.cs_s = {mem_reg.cs_s[0], link.cs_b};
      mem_next.ca_s1 = link.ca;
      mem_next.ca_s2 = mem_reg.ca_s1;
      mem_next.cke_prev = cke;
      for (int i = 0; i < LPS_NUM_BANKS; i++) begin
         mem_next.bstate[i*3 +: 3] = bst_st[i];
      end
      if (mem_reg.cnt != '0) begin
         mem_next.cnt = mem_reg.cnt - 1'b1;
      end
      if (mem_reg.init_cnt != '0) begin
         mem_next.init_cnt = mem_reg.init_cnt - 1'b1;
      end
      if (bank_cmd && (cmd == LPS_CMD_RD || cmd == LPS_CMD_WR)) begin
         mem_next.last_bank = ba;
      end
      if (|bill) begin
         mem_next.illegal = 1'b1;
      end
      if (bank_cmd && cmd == LPS_CMD_BST && !(|burst_terminate_cmd)) begin
         mem_next.illegal = 1'b1;
      end
      unique case (mem_reg.dev)
         LPS_APD, LPS_IPD, LPS_RPD, LPS_SREF, LPS_DEEP: begin
            if (!mem_reg.cke_prev && cke) begin
               if (!cs_b) begin
                  mem_next.illegal = 1'b1;
               end
               unique case (mem_reg.dev)
                  LPS_DEEP: mem_next.dev = LPS_PWR_ON; // Deep exit.
                  LPS_RPD: mem_next.dev = (mem_reg.init_cnt == '0) ? LPS_RUN : LPS_RESETTING;
                  default: mem_next.dev = LPS_RUN;
               endcase
            end
         end
         LPS_RUN, LPS_RESETTING, LPS_PWR_ON: begin
            if (mem_reg.cke_prev && !cke) begin
               if (mem_reg.dev == LPS_RESETTING && cs_b) begin
                  mem_next.dev = LPS_RPD;
               end else if (mem_reg.dev != LPS_RUN) begin
                  mem_next.illegal = 1'b1;
               end else if (cs_b) begin
                  mem_next.dev = any_active ? LPS_APD : LPS_IPD;
               end else if (all_idle && cmd == LPS_CMD_SREF) begin
                  mem_next.dev = LPS_SREF;
               end else if (all_idle && cmd == LPS_CMD_DSLEEP) begin
                  mem_next.dev = LPS_DEEP;
               end else begin
                  mem_next.illegal = 1'b1;
               end
            end else if (cke && mem_reg.cke_prev && cmd != LPS_CMD_NOP) begin
               if (cmd == LPS_CMD_MRW && ca[9:4] == '1 &&
                   (mem_reg.dev != LPS_RUN || all_idle)) begin
                  mem_next.dev = LPS_RESETTING;
                  mem_next.init_cnt = LPS_CNT_W'(INIT_CYC);
               end else if (mem_reg.dev == LPS_RESETTING && cmd == LPS_CMD_MRR) begin
                  mem_next.dev = LPS_MRR_ST;
                  mem_next.cnt = LPS_CNT_W'(LPS_MRR_CYC);
               end else if (mem_reg.dev != LPS_RUN) begin
                  mem_next.illegal = 1'b1;
               end else if (cmd == LPS_CMD_REFAB || cmd == LPS_CMD_MRW ||
                            (cmd == LPS_CMD_MRR && all_idle)) begin
                  if (!all_idle) begin
                     mem_next.illegal = 1'b1;
                  end else begin
                     mem_next.dev = (cmd == LPS_CMD_REFAB) ? LPS_REFAB_ST :
                                    (cmd == LPS_CMD_MRW) ? LPS_MRW_ST : LPS_MRR_ST;
                     mem_next.cnt = LPS_CNT_W'((cmd == LPS_CMD_REFAB) ? LPS_RFCAB_CYC :
                                    (cmd == LPS_CMD_MRW) ? LPS_MRW_CYC : LPS_MRR_CYC);
                  end
               end else if (cmd == LPS_CMD_PRE && ca[LPS_AB_BIT]) begin
                  mem_next.dev = LPS_REFAB_ST;
                  mem_next.cnt = LPS_CNT_W'(LPS_RP_CYC);
               end
            end
         end
         LPS_MRW_ST, LPS_MRR_ST, LPS_REFAB_ST: begin
            if (mem_reg.cnt <= LPS_CNT_W'(1)) begin
               mem_next.dev = LPS_RUN;
            end
            if (cke && mem_reg.cke_prev && cmd != LPS_CMD_NOP) begin
               mem_next.illegal = 1'b1;
            end
         end
         default: mem_next.illegal = 1'b1;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mem_reg <= '{cke_s: 2'b00, cs_s: 2'b11, ca_s1: '0, ca_s2: '0, cke_prev: 1'b0,
                      dev: LPS_PWR_ON, cnt: '0, init_cnt: '0, last_bank: '0,
                      illegal: 1'b0, bstate: '0};
      end else begin
         mem_reg <= mem_next;
      end
   end

   assign o_dev_state = mem_reg.dev;
   assign o_illegal = mem_reg.illegal;
endmodule // lps_mem

// file: logic/lps_ctrl.sv
// Controller end: drives one request onto the link and observes exit wait times.
module lps_ctrl
   import lps_pkg::*;
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // User request: raw select and bus, with requested clock-enable level.
   input wire logic i_req,
   input wire logic i_cs_b,
   input wire logic i_cke,
   input wire logic [LPS_CA_W-1:0] i_ca,
   input wire logic i_from_sref,
   output logic o_ready,
   // Link toward the device.
   lps_if.ctrl link
);
   typedef struct packed {
      logic cke;
      logic cs_b;
      logic [LPS_CA_W-1:0] ca;
      logic [LPS_CNT_W-1:0] wait_cnt;
   } lps_ctrl_s;

   lps_ctrl_s ctl_reg;
   lps_ctrl_s ctl_next;

   // ==========================================================================
   // Request register with exit holdoff
   // ==========================================================================
   always_comb begin
      ctl_next = ctl_reg;
      ctl_next.cs_b = 1'b1;
      ctl_next.ca = '0;
      if (ctl_reg.wait_cnt != '0) begin
         ctl_next.wait_cnt = ctl_reg.wait_cnt - 1'b1;
      end
      if (i_req && o_ready) begin
         ctl_next.cke = i_cke;
         ctl_next.cs_b = i_cs_b;
         ctl_next.ca = i_ca;
         if (!ctl_reg.cke && i_cke) begin
            ctl_next.cs_b = 1'b1;
            ctl_next.wait_cnt = LPS_CNT_W'(i_from_sref ? LPS_XSR_CYC : LPS_XP_CYC);
         end
      end
   end

   assign o_ready = ctl_reg.wait_cnt == '0;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctl_reg <= '{cke: 1'b0, cs_b: 1'b1, ca: '0, wait_cnt: '0};
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign link.cke = ctl_reg.cke;
   assign link.cs_b = ctl_reg.cs_b;
   assign link.ca = ctl_reg.ca;
endmodule // lps_ctrl

// file: bench/lps_link_props.sv
// Concurrent checks on the command link between the two ends.
module lps_link_props
   import lps_pkg::*;
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Link signals.
   input wire logic cke,
   input wire logic cs_b,
   input wire logic [LPS_CA_W-1:0] ca
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);
   logic cke_q_reg;
   logic sref_reg;
   // =======
   // Helpers
   // Self refresh is tracked because its exit needs a longer quiet spell than power-down.
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cke_q_reg <= 1'b0;
         sref_reg <= 1'b0;
      end else begin
         cke_q_reg <= cke;
         if (cke_q_reg && !cke && !cs_b && ca[2:0] == 3'b100) begin
            sref_reg <= 1'b1;
         end else if (cke) begin
            sref_reg <= 1'b0;
         end
      end
   end
   // A selected command with clock enable high on both edges.
   sequence issued(op);
      cke && cke_q_reg && !cs_b && ca[3:0] == op;
   endsequence
   sequence pd_exit;
      $rose(cke);
   endsequence
   sequence pd_entry;
      $fell(cke);
   endsequence
   // =======
   // Checks
   exit_deselect_a: assert property (pd_exit |-> cs_b)
      else $error("clock enable rose while selected");
   exit_quiet_a: assert property (pd_exit |-> cs_b ##1 cs_b)
      else $error("command inside power-down exit time");
   sref_quiet_a: assert property (pd_exit and sref_reg |-> cs_b[*7])
      else $error("command inside self refresh exit time");
   entry_code_a: assert property (pd_entry and !cs_b |-> ca[2:0] inside {3'b100, 3'b011})
      else $error("selected entry without entry code");
   low_hold_a: assert property (pd_entry |=> !cke)
      else $error("clock enable pulsed low for one edge");
   refab_quiet_a: assert property (issued(4'hc) |=> cs_b[*7])
      else $error("command during all-bank refresh");
   mrw_quiet_a: assert property (issued(4'h0) |=> cs_b[*5])
      else $error("command during mode write");
   mrr_quiet_a: assert property (issued(4'h8) |=> cs_b[*2])
      else $error("command during mode read");
endmodule // lps_link_props

// file: bench/testbench.sv
// Self-checking bench joining controller and device ends over the command link.
module testbench
   import lps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_req = 1'b0;
   logic i_cs_b = 1'b1;
   logic i_cke = 1'b0;
   logic [LPS_CA_W-1:0] i_ca = 10'h000;
   logic i_from_sref = 1'b0;
   logic o_ready;
   lps_dev_e o_dev_state;
   logic [LPS_NUM_BANKS*3-1:0] o_bank_states;
   logic o_illegal;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   logic [LPS_CA_W-1:0] gcmd [3] = '{10'h000, 10'h00c, 10'h008};
   lps_dev_e gst [3] = '{LPS_MRW_ST, LPS_REFAB_ST, LPS_MRR_ST};
   lps_if link_bus();
   lps_ctrl i_lps_ctrl (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(i_req),
      .i_cs_b(i_cs_b), .i_cke(i_cke), .i_ca(i_ca), .i_from_sref(i_from_sref),
      .o_ready(o_ready), .link(link_bus.ctrl));
   // Short init count keeps the resetting power-down exit quick.
   lps_mem #(.INIT_CYC(4)) i_lps_mem (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .link(link_bus.mem), .o_dev_state(o_dev_state), .o_bank_states(o_bank_states),
      .o_illegal(o_illegal));
   lps_link_props i_lps_link_props (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .cke(link_bus.cke), .cs_b(link_bus.cs_b), .ca(link_bus.ca));
   always #10 i_core_clk = ~i_core_clk;
   // =======
   // Tasks
   task automatic close_out();
      $display("Counts: %0d mismatches in %0d compares", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Holds the request until ready is seen or 20 cycles pass, counting a mismatch on timeout.
   task automatic req(input logic cs, input logic ck, input logic [LPS_CA_W-1:0] ca,
      input logic fs);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_req <= 1'b1;
      i_cs_b <= cs;
      i_cke <= ck;
      i_ca <= ca;
      i_from_sref <= fs;
      do begin
         @(negedge i_core_clk);
         n++;
      end while (o_ready !== 1'b1 && n < 20);
      if (o_ready !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH ready expected 1 seen %0h", o_ready);
      end
      @(posedge i_core_clk);
      i_req <= 1'b0;
   endtask
   task automatic chk_dev(input lps_dev_e exp);
      int n;
      n = 0;
      while (o_dev_state !== exp && n < 30) begin
         @(negedge i_core_clk);
         n++;
      end
      compares++;
      if (o_dev_state !== exp) begin
         error_cnt++;
         $display("MISMATCH dev_state expected %s seen %s", exp.name(), o_dev_state.name());
      end
   endtask
   task automatic chk_bank(input int b, input lps_bank_e exp);
      int n;
      n = 0;
      while (o_bank_states[b*3 +: 3] !== exp && n < 30) begin
         @(negedge i_core_clk);
         n++;
      end
      compares++;
      if (o_bank_states[b*3 +: 3] !== exp) begin
         error_cnt++;
         $display("MISMATCH bank%0d expected %0h seen %0h", b, exp, o_bank_states[b*3 +: 3]);
      end
   endtask
   task automatic chk_ill(input logic exp);
      repeat (6) @(negedge i_core_clk);
      compares++;
      if (o_illegal !== exp) begin
         error_cnt++;
         $display("MISMATCH illegal expected %0h seen %0h", exp, o_illegal);
      end
   endtask
   // A hang is cut short well past the longest expected run.
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   // =======
   // Tests
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      chk_dev(LPS_PWR_ON);
      // Clock enable must be up, deselected, before the reset command can be decoded.
      req(1'b1, 1'b1, 10'h000, 1'b0);
      req(1'b0, 1'b1, 10'h3f0, 1'b0);
      chk_dev(LPS_RESETTING);
      req(1'b1, 1'b0, 10'h000, 1'b0);
      chk_dev(LPS_RPD);
      req(1'b0, 1'b0, 10'h102, 1'b0);
      repeat (8) @(negedge i_core_clk);
      chk_dev(LPS_RPD);
      chk_bank(2, LPS_B_IDLE);
      req(1'b1, 1'b1, 10'h000, 1'b0);
      chk_dev(LPS_RUN);
      // Timed global states, each returning to the run state.
      foreach (gcmd[i]) begin
         req(1'b0, 1'b1, gcmd[i], 1'b0);
         chk_dev(gst[i]);
         chk_dev(LPS_RUN);
      end
      req(1'b0, 1'b1, 10'h102, 1'b0);
      chk_bank(2, LPS_B_ACTIVE);
      req(1'b1, 1'b0, 10'h000, 1'b0);
      chk_dev(LPS_APD);
      req(1'b1, 1'b1, 10'h000, 1'b0);
      chk_dev(LPS_RUN);
      // Terminate is sent straight after the read so it lands inside the burst.
      req(1'b0, 1'b1, 10'h105, 1'b0);
      req(1'b0, 1'b1, 10'h003, 1'b0);
      chk_bank(2, LPS_B_ACTIVE);
      chk_ill(1'b0);
      req(1'b0, 1'b1, 10'h108, 1'b0);
      chk_bank(2, LPS_B_MRREADING);
      chk_bank(2, LPS_B_ACTIVE);
      req(1'b0, 1'b1, 10'h101, 1'b0);
      chk_bank(2, LPS_B_WRITING);
      chk_bank(2, LPS_B_ACTIVE);
      req(1'b0, 1'b1, 10'h10b, 1'b0);
      chk_bank(2, LPS_B_IDLE);
      req(1'b0, 1'b1, 10'h18b, 1'b0);
      chk_bank(3, LPS_B_PRECHARGING);
      chk_bank(3, LPS_B_IDLE);
      req(1'b0, 1'b1, 10'h084, 1'b0);
      chk_bank(1, LPS_B_REFRESHING);
      chk_bank(1, LPS_B_IDLE);
      req(1'b0, 1'b1, 10'h102, 1'b0);
      chk_bank(2, LPS_B_ACTIVE);
      req(1'b0, 1'b1, 10'h01b, 1'b0);
      chk_dev(LPS_REFAB_ST);
      chk_bank(2, LPS_B_IDLE);
      req(1'b1, 1'b0, 10'h000, 1'b0);
      chk_dev(LPS_IPD);
      req(1'b1, 1'b1, 10'h000, 1'b0);
      chk_dev(LPS_RUN);
      req(1'b0, 1'b0, 10'h004, 1'b0);
      chk_dev(LPS_SREF);
      req(1'b1, 1'b1, 10'h000, 1'b1);
      chk_dev(LPS_RUN);
      req(1'b0, 1'b0, 10'h003, 1'b0);
      chk_dev(LPS_DEEP);
      req(1'b1, 1'b1, 10'h000, 1'b0);
      chk_dev(LPS_PWR_ON);
      chk_ill(1'b0);
      req(1'b0, 1'b1, 10'h102, 1'b0);
      chk_ill(1'b1);
      close_out();
   end
endmodule // testbench
